// ==== verilog/afpc_top.sv ====
`timescale 1ns/1ps
module afpc_top #(
  parameter longint CLK_HZ = 250_000_000
) (
  // Clock and reset
  input  wire logic       I_CORE_CLK,
  input  wire logic       I_ARST_N,
  // Register port
  input  wire logic [7:0] I_REG_ADDR,
  input  wire logic [7:0] I_REG_WDATA,
  input  wire logic       I_REG_WR,
  output logic      [7:0] O_REG_RDATA,
  // Temperatures in whole degrees
  input  wire logic [7:0] I_LOCAL_TEMP,
  input  wire logic [7:0] I_REMOTE_TEMP,
  // Fan drive
  output logic            O_PWM,
  output logic      [7:0] O_DUTY_SLOTS,
  output logic      [3:0] O_TACH_DIVISOR
);
  logic [7:0]  mode_config;
  logic [7:0]  fan_char;
  logic [7:0]  fan_min_duty;
  logic [7:0]  fan_filter;
  logic [7:0]  local_limits;
  logic [7:0]  remote_limits;
  logic [7:0]  target_slots;
  logic [7:0]  filt_slots;
  logic [7:0]  cmd_slots;
  logic [7:0]  last_cmd;
  logic [7:0]  duty_slots;
  logic [7:0]  period_duty;
  logic [7:0]  slot_idx;
  logic [39:0] slot_acc;
  logic [39:0] slot_sum;
  logic        slot_tick;
  logic [31:0] spin_cnt;
  logic [39:0] upd_cnt;
  logic        upd_tick;
  logic        spinning;
  logic [3:0]  local_code;
  logic [3:0]  remote_code;
  logic [3:0]  auto_code;
  logic [7:0]  step;
  logic        filt_on;
  logic        spin_start;

  // Slot modulus; CLK_HZ must exceed 240 slots at 93.5 Hz
  localparam logic [39:0] SLOT_MOD = 40'(CLK_HZ * 1000);

  // Loop duty code for one channel
  function automatic logic [3:0] chan_code(input logic [7:0] temp,
                                           input logic [7:0] lim,
                                           input logic [3:0] minc);
    logic [7:0] tmin;
    logic [7:0] diff;
    logic [2:0] r;
    logic [8:0] inc;
    logic [9:0] sum;
    tmin = {1'b0, lim[7:3], 2'b00};
    diff = 8'(temp - tmin);
    r    = (lim[2:0] > afpc_pkg::RANGE_CODE_MAX) ? afpc_pkg::RANGE_CODE_MAX : lim[2:0];
    inc  = 9'({diff, 1'b0} >> r);
    sum  = 10'(minc) + 10'(inc);
    if (temp < tmin)
      chan_code = 4'h0;
    else if (sum > 10'(afpc_pkg::FULL_DUTY_CODE))
      chan_code = afpc_pkg::FULL_DUTY_CODE;
    else
      chan_code = sum[3:0];
  endfunction

  function automatic logic [39:0] slot_inc(input logic [2:0] code);
    slot_inc = 40'(longint'(afpc_pkg::PWM_MHZ[code]) * longint'(afpc_pkg::SLOTS_PER_PERIOD));
  endfunction

  function automatic logic [31:0] spin_cycles(input logic [2:0] code);
    spin_cycles = 32'((CLK_HZ * longint'(afpc_pkg::SPIN_MS[code])) / 1000);
  endfunction

  function automatic logic [39:0] upd_cycles(input logic [2:0] code);
    longint p;
    p = ((CLK_HZ * afpc_pkg::UPDATE_SIXTEENTHS) / 16) >> code;
    upd_cycles = (p < 1) ? 40'h1 : 40'(p);
  endfunction

  // Register writes
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      mode_config   <= afpc_pkg::RST_MODE_CONFIG;
      fan_char      <= afpc_pkg::RST_FAN_CHAR;
      fan_min_duty  <= afpc_pkg::RST_FAN_MIN_DUTY;
      fan_filter    <= afpc_pkg::RST_FAN_FILTER;
      local_limits  <= afpc_pkg::RST_LOCAL_LIMITS;
      remote_limits <= afpc_pkg::RST_REMOTE_LIMITS;
    end
    else if (I_REG_WR)
    begin
      unique case (I_REG_ADDR)
        afpc_pkg::OFS_MODE_CONFIG:   mode_config   <= I_REG_WDATA;
        afpc_pkg::OFS_FAN_CHAR:      fan_char      <= I_REG_WDATA;
        afpc_pkg::OFS_FAN_MIN_DUTY:  fan_min_duty  <= {4'h0, I_REG_WDATA[3:0]};
        afpc_pkg::OFS_FAN_FILTER:    fan_filter    <= {I_REG_WDATA[7:2], 1'b0, I_REG_WDATA[0]};
        afpc_pkg::OFS_LOCAL_LIMITS:  local_limits  <= I_REG_WDATA;
        afpc_pkg::OFS_REMOTE_LIMITS: remote_limits <= I_REG_WDATA;
        default:                     ;
      endcase
    end
  end

  // Register reads
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_REG_RDATA <= 8'h00;
    else
    begin
      unique case (I_REG_ADDR)
        afpc_pkg::OFS_MODE_CONFIG:   O_REG_RDATA <= mode_config;
        afpc_pkg::OFS_FAN_CHAR:      O_REG_RDATA <= fan_char;
        afpc_pkg::OFS_FAN_MIN_DUTY:  O_REG_RDATA <= fan_min_duty;
        afpc_pkg::OFS_FAN_FILTER:    O_REG_RDATA <= fan_filter;
        afpc_pkg::OFS_LOCAL_LIMITS:  O_REG_RDATA <= local_limits;
        afpc_pkg::OFS_REMOTE_LIMITS: O_REG_RDATA <= remote_limits;
        default:                     O_REG_RDATA <= 8'h00;
      endcase
    end
  end

  // (R5) Tach divisor
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_TACH_DIVISOR <= 4'h1;
    else
      O_TACH_DIVISOR <= 4'(4'h1 << fan_char[7:6]);
  end

  // Channel loop codes
  always_comb
  begin
    // (R7) (R8) (R9) (R19) (R21) Linear loop per channel
    local_code  = chan_code(I_LOCAL_TEMP, local_limits, fan_min_duty[3:0]);
    remote_code = chan_code(I_REMOTE_TEMP, remote_limits, fan_min_duty[3:0]);
    // (R2) Remote only or larger of both
    if (mode_config[afpc_pkg::BIT_SEL_HI] && mode_config[afpc_pkg::BIT_SEL_LO])
      auto_code = (local_code > remote_code) ? local_code : remote_code;
    else
      auto_code = remote_code;
    // (R14) Ramp step in slots
    step = 8'(8'h1 << fan_filter[6:5]);
  end

  // (R1) (R6) (R20) Target duty from automatic loop or software code
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      target_slots <= 8'h00;
    else if (mode_config[afpc_pkg::BIT_AUTO])
      target_slots <= 8'(auto_code * afpc_pkg::SLOTS_PER_CODE);
    else
      target_slots <= 8'(fan_min_duty[3:0] * afpc_pkg::SLOTS_PER_CODE);
  end

  // (R15) (R16) Temperature update tick from sample-rate code
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      upd_cnt  <= 40'h0;
      upd_tick <= 1'b0;
    end
    else if (upd_cnt + 40'h1 >= upd_cycles(fan_filter[4:2]))
    begin
      upd_cnt  <= 40'h0;
      upd_tick <= 1'b1;
    end
    else
    begin
      upd_cnt  <= upd_cnt + 40'h1;
      upd_tick <= 1'b0;
    end
  end

  // (R13) Filtered duty steps toward target on each update
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      filt_slots <= 8'h00;
    // Previous duty follows the target duty while unfiltered
    else if (!filt_on)
      filt_slots <= target_slots;
    else if (upd_tick)
    begin
      if (target_slots > filt_slots)
        filt_slots <= (target_slots - filt_slots > step) ? 8'(filt_slots + step)
                                                         : target_slots;
      else if (target_slots < filt_slots)
        filt_slots <= (filt_slots - target_slots > step) ? 8'(filt_slots - step)
                                                         : target_slots;
    end
  end

  // (R10) (R18) Filtered or immediate command
  always_comb
  begin
    filt_on = fan_filter[afpc_pkg::BIT_FILTER_EN] && mode_config[afpc_pkg::BIT_AUTO];
    if (filt_on)
      cmd_slots = filt_slots;
    else
      cmd_slots = target_slots;
  end

  // (R22) (R17) Spin-up start detect
  always_comb
  begin
    spin_start = (cmd_slots != 8'h00) && (last_cmd == 8'h00)
                 && !fan_filter[afpc_pkg::BIT_SPIN_OFF];
  end

  // (R22) (R3) (R17) Spin-up from standstill
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      last_cmd <= 8'h00;
      spin_cnt <= 32'h0;
      spinning <= 1'b0;
    end
    else
    begin
      last_cmd <= cmd_slots;
      if (cmd_slots == 8'h00)
        spinning <= 1'b0;
      else if (spin_start)
      begin
        spinning <= 1'b1;
        spin_cnt <= spin_cycles(fan_char[2:0]) - 32'h1;
      end
      else if (spinning)
      begin
        if (spin_cnt <= 32'h1)
          spinning <= 1'b0;
        spin_cnt <= spin_cnt - 32'h1;
      end
    end
  end

  // Applied duty
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      duty_slots <= 8'h00;
    else if (spinning || spin_start)
      duty_slots <= afpc_pkg::SLOTS_PER_PERIOD;
    else
      duty_slots <= cmd_slots;
  end

  // (R4) Fractional divider, one-cycle slot enable
  always_comb
  begin
    slot_sum  = slot_acc + slot_inc(fan_char[5:3]);
    slot_tick = (slot_sum >= SLOT_MOD);
  end

  // (R4) (R12) Slot timer and 240-slot period
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      slot_acc    <= 40'h0;
      slot_idx    <= 8'h00;
      period_duty <= 8'h00;
    end
    else if (slot_tick)
    begin
      slot_acc <= slot_sum - SLOT_MOD;
      if (slot_idx == afpc_pkg::SLOTS_PER_PERIOD - 8'h1)
      begin
        slot_idx    <= 8'h00;
        period_duty <= duty_slots;
      end
      else
        slot_idx <= slot_idx + 8'h1;
    end
    else
      slot_acc <= slot_sum;
  end

  // (R12) High for the programmed number of slots
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_PWM        <= 1'b0;
      O_DUTY_SLOTS <= 8'h00;
    end
    else
    begin
      O_PWM        <= (slot_idx < period_duty);
      O_DUTY_SLOTS <= duty_slots;
    end
  end
endmodule

// ==== verilog/afpc_pkg.sv ====
// What this block does
// (R1) Mode bit 7: automatic loop or software duty
// (R2) Bits 6:5 pick remote or larger duty
// (R3) Spin-up time code selects 200 ms..8 s
// (R4) PWM frequency code selects 11.7..93.5 Hz
// (R5) Speed range code selects tach divisor 1..8
// (R6) Low nibble gives minimum duty code
// (R7) Local turn-on temperature in 4 degree steps
// (R8) Local range code selects 5..80 degrees
// (R9) Remote register holds own minimum and range
// (R10) Filter bit 0 enables ramped duty
// (R11) Software programs everything before automatic mode
// (R12) Period split into 240 duty slots
// (R13) Filtered duty steps toward new target
// (R14) Ramp field selects 1, 2, 4, 8 slots
// (R15) Sample-rate field selects 87.5 Hz..11.2 kHz; the code updates at 1/16 Hz..8 Hz instead
// (R16) One filtered step per temperature update
// (R17) Filter bit 7 skips spin-up
// (R18) Unfiltered duty applies immediately
// (R19) Duty rises linearly up to code 15
// (R20) Duty codes are fifteenths of full scale
// (R21) Below minimum temperature duty is zero
// (R22) Spin-up drives full duty from standstill
package afpc_pkg;
  localparam logic [7:0] OFS_MODE_CONFIG    = 8'h00;
  localparam logic [7:0] OFS_FAN_CHAR       = 8'h20;
  localparam logic [7:0] OFS_FAN_MIN_DUTY   = 8'h22;
  localparam logic [7:0] OFS_FAN_FILTER     = 8'h23;
  localparam logic [7:0] OFS_LOCAL_LIMITS   = 8'h24;
  localparam logic [7:0] OFS_REMOTE_LIMITS  = 8'h25;

  localparam logic [7:0] RST_MODE_CONFIG    = 8'h80;
  localparam logic [7:0] RST_FAN_CHAR       = 8'h5d;
  localparam logic [7:0] RST_FAN_MIN_DUTY   = 8'h05;
  localparam logic [7:0] RST_FAN_FILTER     = 8'h10;
  localparam logic [7:0] RST_LOCAL_LIMITS   = 8'h43;
  localparam logic [7:0] RST_REMOTE_LIMITS  = 8'h43;

  localparam int BIT_AUTO        = 7;
  localparam int BIT_SEL_HI      = 6;
  localparam int BIT_SEL_LO      = 5;
  localparam int BIT_SPIN_OFF    = 7;
  localparam int BIT_FILTER_EN   = 0;

  localparam logic [7:0] SLOTS_PER_PERIOD = 8'hf0;
  localparam logic [7:0] SLOTS_PER_CODE   = 8'h10;
  localparam logic [3:0] FULL_DUTY_CODE   = 4'hf;
  localparam logic [2:0] RANGE_CODE_MAX   = 3'h4;

  // Spin-up times in ms
  localparam int SPIN_MS [8] = '{200, 400, 600, 800, 1000, 2000, 4000, 8000};
  // PWM frequencies in mHz
  localparam int PWM_MHZ [8] = '{11700, 15600, 23400, 31250, 37500, 46900, 62500, 93500};
  // Update period in units of 1/16 s, shifted right by the sample-rate code
  localparam int UPDATE_SIXTEENTHS = 256;
endpackage

// ==== tb/afpc_fan_model.sv ====
`timescale 1ns/1ps
module afpc_fan_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Drive from the block
  input  wire logic        i_pwm,
  // Last full period seen
  output logic      [15:0] o_period,
  output logic      [15:0] o_high
);
  logic [15:0] cnt;
  logic [15:0] hcnt;
  logic        last;
  // Measures each period from rising edge to rising edge
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt      <= 16'h0000;
      hcnt     <= 16'h0000;
      last     <= 1'b0;
      o_period <= 16'h0000;
      o_high   <= 16'h0000;
    end
    else
    begin
      last <= i_pwm;
      if (i_pwm && !last)
      begin
        o_period <= cnt;
        o_high   <= hcnt;
        cnt      <= 16'h0001;
        hcnt     <= 16'h0001;
      end
      else
      begin
        cnt  <= cnt + 16'h0001;
        hcnt <= hcnt + {15'h0000, i_pwm};
      end
    end
  end
endmodule

// ==== tb/afpc_sva.sv ====
`timescale 1ns/1ps
module afpc_sva (
  // Clock and reset
  input wire logic       I_CORE_CLK,
  input wire logic       I_ARST_N,
  // Register port
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic       I_REG_WR,
  input wire logic [7:0] O_REG_RDATA,
  // Fan drive
  input wire logic [7:0] O_DUTY_SLOTS,
  input wire logic [3:0] O_TACH_DIVISOR
);
  default clocking @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_ARST_N);
  logic [7:0] filt;
  logic [7:0] step;
  logic       auto_on;
  // Shadow of the filter register
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      filt <= 8'h10;
    else if (I_REG_WR && I_REG_ADDR == 8'h23)
      filt <= I_REG_WDATA;
  end
  // Shadow of the automatic mode bit
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      auto_on <= 1'b1;
    else if (I_REG_WR && I_REG_ADDR == 8'h00)
      auto_on <= I_REG_WDATA[7];
  end
  assign step = 8'h01 << filt[6:5];
  sequence s_wr_lim;
    I_REG_WR && I_REG_ADDR == 8'h24 ##1 $stable(I_REG_ADDR);
  endsequence
  property p_rd_back;
    s_wr_lim |=> O_REG_RDATA == $past(I_REG_WDATA, 2);
  endproperty
  a_rd_back: assert property (p_rd_back) else $error("limit readback");
  property p_unmapped;
    I_REG_ADDR == 8'h10 |=> O_REG_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_min_mask;
    I_REG_ADDR == 8'h22 |=> O_REG_RDATA[7:4] == 4'h0;
  endproperty
  a_min_mask: assert property (p_min_mask) else $error("min duty high bits");
  property p_filt_bit1;
    I_REG_ADDR == 8'h23 |=> !O_REG_RDATA[1];
  endproperty
  a_filt_bit1: assert property (p_filt_bit1) else $error("filter bit 1");
  property p_tach;
    I_REG_WR && I_REG_ADDR == 8'h20 |-> ##2 O_TACH_DIVISOR == 4'h1 << $past(I_REG_WDATA[7:6], 2);
  endproperty
  a_tach: assert property (p_tach) else $error("tach divisor");
  property p_duty_max;
    O_DUTY_SLOTS <= 8'hf0;
  endproperty
  a_duty_max: assert property (p_duty_max) else $error("duty above period");
  property p_unfilt;
    !filt[0] [*8] |-> O_DUTY_SLOTS[3:0] == 4'h0;
  endproperty
  a_unfilt: assert property (p_unfilt) else $error("unfiltered duty code");
  property p_filt_step;
    (filt[0] && filt[7] && auto_on) [*8] |-> ((O_DUTY_SLOTS > $past(O_DUTY_SLOTS)) ?
      O_DUTY_SLOTS - $past(O_DUTY_SLOTS) : $past(O_DUTY_SLOTS) - O_DUTY_SLOTS) <= step;
  endproperty
  a_filt_step: assert property (p_filt_step) else $error("ramp step too large");
endmodule
bind afpc_top afpc_sva chk_u (.I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR),
  .O_REG_RDATA(O_REG_RDATA), .O_DUTY_SLOTS(O_DUTY_SLOTS), .O_TACH_DIVISOR(O_TACH_DIVISOR));

// ==== tb/auto_fan_pwm_control_loop_test.sv ====
`timescale 1ns/1ps
module auto_fan_pwm_control_loop_test;
  localparam longint CLK = 24000;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [7:0]  addr = 0;
  logic [7:0]  wdata = 0;
  logic        wr = 0;
  logic [7:0]  lt = 0;
  logic [7:0]  rt = 0;
  logic [7:0]  rdata;
  logic        pwm;
  logic [7:0]  duty;
  logic [3:0]  tach;
  logic [15:0] per;
  logic [15:0] hi;
  logic [7:0]  e;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          d0;
  int          p;
  int          lts[4] = '{30, 0, 60, 5};
  int          rts[4] = '{10, 30, 100, 20};
  afpc_top #(.CLK_HZ(CLK)) dut_u (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .I_REG_WR(wr), .O_REG_RDATA(rdata), .I_LOCAL_TEMP(lt),
    .I_REMOTE_TEMP(rt), .O_PWM(pwm), .O_DUTY_SLOTS(duty), .O_TACH_DIVISOR(tach));
  afpc_fan_model fan_u (.i_clk(clk), .i_rst_n(rst_n), .i_pwm(pwm), .o_period(per), .o_high(hi));
  initial forever #2 clk = ~clk;
  task automatic finish_test();
    $display("Errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    samples_checked++;
    if (s !== x)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] x);
    @(negedge clk);
    addr = a;
    repeat (2) @(negedge clk);
    chk(rdata, x);
  endtask
  function automatic int slots(input int t, input int lim);
    int tm;
    int r;
    tm = (lim >> 3) * 4;
    r = (lim & 7) > 4 ? 4 : (lim & 7);
    if (t < tm)
      return 0;
    return ((5 + (((t - tm) * 2) >> r)) > 15 ? 15 : 5 + (((t - tm) * 2) >> r)) * 16;
  endfunction
  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    rreg(8'h00, 8'h80); // auto default
    rreg(8'h20, 8'h5d); // fan defaults
    rreg(8'h22, 8'h05); // min duty
    rreg(8'h23, 8'h10); // filter defaults
    rreg(8'h24, 8'h43); // local limits
    rreg(8'h25, 8'h43); // remote limits
    wreg(8'h22, 8'hf5);
    rreg(8'h22, 8'h05); // nibble only
    wreg(8'h10, 8'h55);
    rreg(8'h10, 8'h00); // unmapped ignored
    for (int c = 0; c < 4; c++)
    begin
      wreg(8'h20, {c[1:0], 6'h1d});
      repeat (3) @(negedge clk);
      chk(tach, 4'h1 << c); // divisor
    end
    wreg(8'h23, 8'h90);
    wreg(8'h00, 8'h00);
    repeat (6) @(negedge clk);
    chk(duty, 8'h50); // software duty
    wreg(8'h24, 8'h03);
    rreg(8'h24, 8'h03); // range code
    wreg(8'h25, 8'h2a);
    for (int m = 0; m < 2; m++)
    begin
      wreg(8'h00, m ? 8'he0 : 8'h80);
      for (int i = 0; i < 4; i++)
      begin
        lt = lts[i];
        rt = rts[i];
        repeat (6) @(negedge clk);
        e = 8'(slots(rts[i], 8'h2a));
        if (m && slots(lts[i], 8'h03) > e)
          e = 8'(slots(lts[i], 8'h03));
        chk(duty, e);
      end
    end
    lt = 0;
    rt = 30;
    for (int c = 0; c < 8; c++)
    begin
      wreg(8'h20, {2'b01, c[2:0], 3'b000});
      p = int'(CLK * 1000 / afpc_pkg::PWM_MHZ[c]);
      repeat (3 * p) @(negedge clk);
      chk(per * 50 > p * 49 && per * 50 < p * 51, 1); // frequency
      chk(3 * hi + per / 40 > 2 * per && 3 * hi < 2 * per + per / 40, 1); // slots
    end
    rt = 10;
    wreg(8'h00, 8'h80);
    wreg(8'h23, 8'h10);
    repeat (6) @(negedge clk);
    rt = 30;
    repeat (6) @(negedge clk);
    chk(duty, 8'hf0); // full first
    repeat (CLK / 5 - 20) @(negedge clk);
    chk(duty, 8'hf0); // still spinning
    repeat (30) @(negedge clk);
    chk(duty, 8'ha0); // target after
    rt = 100;
    for (int r = 0; r < 4; r++)
    begin
      // filter set up outside automatic mode
      wreg(8'h00, 8'h00);
      wreg(8'h23, {1'b1, r[1:0], 5'h1d});
      wreg(8'h00, 8'h80);
      repeat (10) @(negedge clk);
      d0 = duty;
      chk(d0 < 240, 1); // no jump
      repeat (CLK / 8) @(negedge clk);
      chk(duty, d0 + (1 << r) > 240 ? 240 : d0 + (1 << r));
    end
    finish_test();
  end
endmodule
